// [rtl/fpwg_pkg.sv]
/*
  Shared constants and types for the flash program write guard: control
  bits, unlock key values, flash geometry, operation timings and the
  state records of both ends.
  Assumes a single 20 MHz system clock shared by both ends.
*/
package fpwg_pkg;

  localparam int FPWG_CLK_HZ = 20_000_000;
  localparam int FPWG_WRITE_TIME_US = 40;
  localparam int FPWG_ERASE_TIME_MS = 10;
  localparam int FPWG_WRITE_CYCLES =
    (FPWG_WRITE_TIME_US * (FPWG_CLK_HZ / 1_000_000) + 0);
  localparam int FPWG_ERASE_CYCLES =
    FPWG_ERASE_TIME_MS * (FPWG_CLK_HZ / 1_000);
  localparam int FPWG_CNT_W = 18;

  localparam int FPWG_ADDR_W = 13;
  localparam int FPWG_FLASH_BYTES = 8192;
  localparam int FPWG_PAGE_BYTES = 512;
  localparam int FPWG_PAGE_W = 9;
  localparam logic [12:0] FPWG_RSVD_LO = 13'h1E00;
  localparam logic [12:0] FPWG_RSVD_HI = 13'h1FFF;
  localparam logic [12:0] FPWG_LOCK_ADDR = 13'h1DFF;
  localparam logic [7:0] FPWG_ERASED = 8'hFF;

  localparam int FPWG_WREN_BIT = 0;
  localparam int FPWG_EREN_BIT = 1;
  localparam logic [7:0] FPWG_KEY1 = 8'hA5;
  localparam logic [7:0] FPWG_KEY2 = 8'hF1;
  localparam logic FPWG_SEL_CTL = 1'b0;
  localparam logic FPWG_SEL_KEY = 1'b1;

  localparam logic [4:0] FPWG_REG_CMD = 5'h00;
  localparam logic [4:0] FPWG_REG_ADDR = 5'h04;
  localparam logic [4:0] FPWG_REG_DATA = 5'h08;
  localparam logic [4:0] FPWG_REG_STATUS = 5'h0C;
  localparam logic [4:0] FPWG_REG_RDATA = 5'h10;
  localparam logic [1:0] FPWG_CMD_PROG = 2'h1;
  localparam logic [1:0] FPWG_CMD_ERASE = 2'h2;
  localparam logic [1:0] FPWG_CMD_READ = 2'h3;
  localparam int FPWG_ST_BUSY = 0;
  localparam int FPWG_ST_DONE = 1;
  localparam int FPWG_ST_ERR = 2;
  localparam logic [1:0] FPWG_RESP_OKAY = 2'h0;
  localparam logic [1:0] FPWG_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {FPWG_K_LOCKED, FPWG_K_HALF, FPWG_K_OPEN}
    fpwg_key_t;
  typedef enum logic [1:0] {FPWG_OP_NONE, FPWG_OP_PROG, FPWG_OP_ERASE}
    fpwg_op_t;
  typedef enum logic [3:0] {FPWG_C_IDLE, FPWG_C_CTL_ON, FPWG_C_KEY1,
    FPWG_C_KEY2, FPWG_C_XWR, FPWG_C_WAIT, FPWG_C_CTL_OFF, FPWG_C_READ,
    FPWG_C_READ_CAP} fpwg_cst_t;

  typedef struct packed {
    logic wr_en;
    logic er_en;
    fpwg_key_t key;
    fpwg_op_t op;
    logic [FPWG_CNT_W-1:0] cnt;
    logic [12:0] addr;
    logic [7:0] data;
    logic [7:0] code_rdata;
    logic ram_wr;
    logic [12:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] dbg_rdata;
    logic dbg_ack;
    logic dbg_denied;
  } fpwg_dev_t;

  typedef struct packed {
    fpwg_cst_t state;
    logic [1:0] op;
    logic [12:0] addr;
    logic [7:0] data;
    logic [7:0] rbyte;
    logic done;
    logic err;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic sfr_wr;
    logic sfr_sel;
    logic xm_wr;
    logic code_rd;
    logic [12:0] mem_addr;
    logic [7:0] wdata;
  } fpwg_ctl_t;

  localparam fpwg_dev_t FPWG_DEV_RST = '0;
  localparam fpwg_ctl_t FPWG_CTL_RST = '0;

endpackage : fpwg_pkg

// [rtl/fpwg_if.sv]
/*
  Core-side bus between the processor core and the flash write guard:
  special-register writes, external-move writes, code-move reads, stall.
  Assumes both ends sit on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface fpwg_if;
  logic sfr_wr;
  logic sfr_sel;
  logic xm_wr;
  logic code_rd;
  logic [12:0] mem_addr;
  logic [7:0] wdata;
  logic [7:0] code_rdata;
  logic stall;

  modport core (
    output sfr_wr,
    output sfr_sel,
    output xm_wr,
    output code_rd,
    output mem_addr,
    output wdata,
    input code_rdata,
    input stall
  );

  modport dev (
    input sfr_wr,
    input sfr_sel,
    input xm_wr,
    input code_rd,
    input mem_addr,
    input wdata,
    output code_rdata,
    output stall
  );
endinterface : fpwg_if
`default_nettype wire

// [rtl/fpwg_dev.sv]
/*
  Flash write guard, device end: control and unlock-key registers, the
  program flash array, steering of external-move writes, timed byte
  program and page erase, code-move reads and a lock-guarded debug port.
  Assumes the core never issues a request while stall is high and that
  all inputs are synchronous to CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module fpwg_dev
  import fpwg_pkg::*;
#(
  parameter int ERASE_CYCLES = FPWG_ERASE_CYCLES,
  parameter int WRITE_CYCLES = FPWG_WRITE_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  fpwg_if.dev BUS,
  output logic RAM_WR,
  output logic [12:0] RAM_ADDR,
  output logic [7:0] RAM_WDATA,
  input wire logic DBG_RD,
  input wire logic DBG_WR,
  input wire logic [12:0] DBG_ADDR,
  input wire logic [7:0] DBG_WDATA,
  output logic [7:0] DBG_RDATA,
  output logic DBG_ACK,
  output logic DBG_DENIED,
  output logic PROG_ENABLE,
  output logic ERASE_ENABLE,
  output logic UNLOCKED
);

  localparam logic [FPWG_CNT_W-1:0] PROG_LOAD =
    FPWG_CNT_W'(WRITE_CYCLES - 1);
  localparam logic [FPWG_CNT_W-1:0] ERASE_LOAD =
    FPWG_CNT_W'(ERASE_CYCLES - 1);

  // nonvolatile array starts out erased in simulation
  logic [7:0] flash_mem [FPWG_FLASH_BYTES] = '{default: FPWG_ERASED};
  fpwg_dev_t q;
  fpwg_dev_t d;
  logic locked;
  logic dbg_req;
  logic dbg_wr_ok;
  logic op_end;

  assign locked = flash_mem[FPWG_LOCK_ADDR] != FPWG_ERASED;
  assign dbg_req = DBG_RD | DBG_WR;
  assign op_end = (q.op != FPWG_OP_NONE) && (q.cnt == '0);
  assign dbg_wr_ok = DBG_WR && !locked && (q.op == FPWG_OP_NONE);

  always_comb begin
    d = q;
    d.ram_wr = 1'b0;
    d.dbg_ack = 1'b0;
    d.dbg_denied = 1'b0;
    if (q.op != FPWG_OP_NONE) begin
      // flash busy: core is held, no register or memory access taken
      if (op_end) begin
        d.op = FPWG_OP_NONE;
      end else begin
        d.cnt = q.cnt - 1'b1;
      end
    end else begin
      if (BUS.sfr_wr && BUS.sfr_sel == FPWG_SEL_CTL) begin
        d.wr_en = BUS.wdata[FPWG_WREN_BIT];
        d.er_en = BUS.wdata[FPWG_EREN_BIT];
      end
      if (BUS.sfr_wr && BUS.sfr_sel == FPWG_SEL_KEY) begin
        // any wrong key, or a key while open, relocks
        case (q.key)
          FPWG_K_LOCKED: begin
            d.key = (BUS.wdata == FPWG_KEY1) ? FPWG_K_HALF : FPWG_K_LOCKED;
          end
          FPWG_K_HALF: begin
            d.key = (BUS.wdata == FPWG_KEY2) ? FPWG_K_OPEN : FPWG_K_LOCKED;
          end
          default: begin
            d.key = FPWG_K_LOCKED;
          end
        endcase
      end
      if (BUS.xm_wr) begin
        if (q.wr_en) begin
          if (q.key == FPWG_K_OPEN) begin
            d.key = FPWG_K_LOCKED;
            d.addr = BUS.mem_addr;
            d.data = BUS.wdata;
            if (q.er_en) begin
              d.op = FPWG_OP_ERASE;
              d.cnt = ERASE_LOAD;
            end else begin
              d.op = FPWG_OP_PROG;
              d.cnt = PROG_LOAD;
            end
          end else begin
            d.key = FPWG_K_LOCKED;
          end
        end else begin
          d.ram_wr = 1'b1;
          d.ram_addr = BUS.mem_addr;
          d.ram_wdata = BUS.wdata;
        end
      end
      if (BUS.code_rd) begin
        d.code_rdata = flash_mem[BUS.mem_addr];
      end
    end
    if (dbg_req) begin
      if (locked || q.op != FPWG_OP_NONE) begin
        d.dbg_denied = 1'b1;
      end else begin
        d.dbg_ack = 1'b1;
        if (DBG_RD) begin
          d.dbg_rdata = flash_mem[DBG_ADDR];
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      q <= FPWG_DEV_RST;
    end else begin
      q <= d;
    end
  end

  // programming only clears bits; erase restores a whole page
  always_ff @(posedge CLK) begin
    if (op_end && q.op == FPWG_OP_PROG) begin
      flash_mem[q.addr] <= flash_mem[q.addr] & q.data;
    end else if (op_end && q.op == FPWG_OP_ERASE) begin
      for (int i = 0; i < FPWG_PAGE_BYTES; i++) begin
        flash_mem[{q.addr[FPWG_ADDR_W-1:FPWG_PAGE_W],
          FPWG_PAGE_W'(i)}] <= FPWG_ERASED;
      end
    end else if (dbg_wr_ok) begin
      flash_mem[DBG_ADDR] <= flash_mem[DBG_ADDR] & DBG_WDATA;
    end
  end

  assign BUS.stall = q.op != FPWG_OP_NONE;
  assign BUS.code_rdata = q.code_rdata;
  assign RAM_WR = q.ram_wr;
  assign RAM_ADDR = q.ram_addr;
  assign RAM_WDATA = q.ram_wdata;
  assign DBG_RDATA = q.dbg_rdata;
  assign DBG_ACK = q.dbg_ack;
  assign DBG_DENIED = q.dbg_denied;
  assign PROG_ENABLE = q.wr_en;
  assign ERASE_ENABLE = q.er_en;
  assign UNLOCKED = q.key == FPWG_K_OPEN;

endmodule : fpwg_dev
`default_nettype wire

// [rtl/fpwg_ctl.sv]
/*
  Flash write guard, core end: takes program, erase and read orders from
  software over AXI4-Lite and plays the enable, unlock, write and
  disable sequence on the core-side bus, waiting out the stall.
  Assumes the device end shares CLK and answers code reads next cycle.
*/
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fpwg_ctl
  import fpwg_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  fpwg_if.core BUS,
  input wire logic [4:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [4:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  fpwg_ctl_t q;
  fpwg_ctl_t d;
  logic wr_go;
  logic rd_go;
  logic busy;
  logic [1:0] cmd;

  assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !q.bvalid;
  assign rd_go = S_AXI_ARVALID && !q.rvalid;
  assign busy = q.state != FPWG_C_IDLE;
  assign cmd = S_AXI_WDATA[1:0];

  always_comb begin
    d = q;
    d.sfr_wr = 1'b0;
    d.xm_wr = 1'b0;
    d.code_rd = 1'b0;
    if (q.bvalid && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end
    case (q.state)
      FPWG_C_IDLE: begin
        if (q.op == FPWG_CMD_READ) begin
          d.code_rd = 1'b1;
          d.mem_addr = q.addr;
          d.state = FPWG_C_READ;
          d.op = '0;
        end else if (q.op != '0) begin
          d.sfr_wr = 1'b1;
          d.sfr_sel = FPWG_SEL_CTL;
          d.wdata = '0;
          d.wdata[FPWG_WREN_BIT] = 1'b1;
          d.wdata[FPWG_EREN_BIT] = q.op == FPWG_CMD_ERASE;
          d.state = FPWG_C_CTL_ON;
        end
      end
      FPWG_C_CTL_ON: begin
        d.sfr_wr = 1'b1;
        d.sfr_sel = FPWG_SEL_KEY;
        d.wdata = FPWG_KEY1;
        d.state = FPWG_C_KEY1;
      end
      FPWG_C_KEY1: begin
        d.sfr_wr = 1'b1;
        d.sfr_sel = FPWG_SEL_KEY;
        d.wdata = FPWG_KEY2;
        d.state = FPWG_C_KEY2;
      end
      FPWG_C_KEY2: begin
        d.xm_wr = 1'b1;
        d.mem_addr = q.addr;
        d.wdata = q.data;
        d.state = FPWG_C_XWR;
      end
      FPWG_C_XWR: begin
        d.state = FPWG_C_WAIT;
      end
      FPWG_C_WAIT: begin
        if (!BUS.stall) begin
          d.sfr_wr = 1'b1;
          d.sfr_sel = FPWG_SEL_CTL;
          d.wdata = '0;
          d.state = FPWG_C_CTL_OFF;
        end
      end
      FPWG_C_CTL_OFF: begin
        d.op = '0;
        d.done = 1'b1;
        d.state = FPWG_C_IDLE;
      end
      FPWG_C_READ: begin
        d.state = FPWG_C_READ_CAP;
      end
      FPWG_C_READ_CAP: begin
        d.rbyte = BUS.code_rdata;
        d.done = 1'b1;
        d.state = FPWG_C_IDLE;
      end
      default: begin
        d.state = FPWG_C_IDLE;
      end
    endcase
    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp = FPWG_RESP_OKAY;
      case (S_AXI_AWADDR)
        FPWG_REG_CMD: begin
          if (S_AXI_WSTRB[0] && !busy && q.op == '0) begin
            // refuse program or erase aimed at the reserved area
            if (cmd != FPWG_CMD_READ && cmd != '0 &&
                q.addr >= FPWG_RSVD_LO && q.addr <= FPWG_RSVD_HI) begin
              d.err = 1'b1;
            end else begin
              d.op = cmd;
            end
          end
        end
        FPWG_REG_ADDR: begin
          if (S_AXI_WSTRB[0]) begin
            d.addr[7:0] = S_AXI_WDATA[7:0];
          end
          if (S_AXI_WSTRB[1]) begin
            d.addr[12:8] = S_AXI_WDATA[12:8];
          end
        end
        FPWG_REG_DATA: begin
          if (S_AXI_WSTRB[0]) begin
            d.data = S_AXI_WDATA[7:0];
          end
        end
        FPWG_REG_STATUS: begin
          // write one to clear; a same-cycle set still wins
          if (S_AXI_WSTRB[0] && S_AXI_WDATA[FPWG_ST_DONE] && !d.done) begin
            d.done = 1'b0;
          end else if (S_AXI_WSTRB[0] && S_AXI_WDATA[FPWG_ST_DONE] &&
                       q.state != FPWG_C_CTL_OFF &&
                       q.state != FPWG_C_READ_CAP) begin
            d.done = 1'b0;
          end
          if (S_AXI_WSTRB[0] && S_AXI_WDATA[FPWG_ST_ERR]) begin
            d.err = 1'b0;
          end
        end
        FPWG_REG_RDATA: begin
        end
        default: begin
          d.bresp = FPWG_RESP_SLVERR;
        end
      endcase
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp = FPWG_RESP_OKAY;
      d.rdata = '0;
      case (S_AXI_ARADDR)
        FPWG_REG_CMD: d.rdata[1:0] = q.op;
        FPWG_REG_ADDR: d.rdata[12:0] = q.addr;
        FPWG_REG_DATA: d.rdata[7:0] = q.data;
        FPWG_REG_STATUS: begin
          d.rdata[FPWG_ST_BUSY] = busy || q.op != '0;
          d.rdata[FPWG_ST_DONE] = q.done;
          d.rdata[FPWG_ST_ERR] = q.err;
        end
        FPWG_REG_RDATA: d.rdata[7:0] = q.rbyte;
        default: d.rresp = FPWG_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      q <= FPWG_CTL_RST;
    end else begin
      q <= d;
    end
  end

  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY = wr_go;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_ARREADY = rd_go;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RRESP = q.rresp;
  assign S_AXI_RDATA = q.rdata;
  assign BUS.sfr_wr = q.sfr_wr;
  assign BUS.sfr_sel = q.sfr_sel;
  assign BUS.xm_wr = q.xm_wr;
  assign BUS.code_rd = q.code_rd;
  assign BUS.mem_addr = q.mem_addr;
  assign BUS.wdata = q.wdata;

endmodule : fpwg_ctl
`default_nettype wire

// [bench/fpwg_sva.sv]
/*
  Checker on the core-side bus between the two ends of the write guard.
  Assumes the device end runs with WRITE_CYCLES 5 and ERASE_CYCLES 20.
*/
`timescale 1ns/1ps
`default_nettype none
module fpwg_sva
  import fpwg_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic sfr_wr,
  input wire logic sfr_sel,
  input wire logic xm_wr,
  input wire logic code_rd,
  input wire logic [12:0] mem_addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] code_rdata,
  input wire logic stall
);
  logic [1:0] ctl_q;
  logic key2_q;
  // last control value written, and whether the previous cycle wrote the second key
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctl_q <= 2'h0;
      key2_q <= 1'b0;
    end else begin
      if (sfr_wr && !sfr_sel) begin
        ctl_q <= wdata[1:0];
      end
      key2_q <= sfr_wr && sfr_sel && (wdata == FPWG_KEY2);
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  chk_key_first: assert property (sfr_wr && !sfr_sel && wdata[0] |=>
    sfr_wr && sfr_sel && wdata == FPWG_KEY1) else $error("no first key");
  chk_key_order: assert property (sfr_wr && sfr_sel && wdata == FPWG_KEY1
    |=> sfr_wr && sfr_sel && wdata == FPWG_KEY2) else $error("key order");
  chk_key_per_byte: assert property (xm_wr |-> key2_q)
    else $error("write without fresh unlock");
  chk_write_stall: assert property (xm_wr && ctl_q == 2'h1 |=>
    stall [*5] ##1 !stall) else $error("program stall length");
  chk_erase_stall: assert property (xm_wr && ctl_q == 2'h3 |=>
    stall ##19 stall ##1 !stall) else $error("erase stall length");
  chk_quiet_stall: assert property (stall |->
    !sfr_wr && !xm_wr && !code_rd) else $error("request while stalled");
  chk_disable_after: assert property ($fell(stall) |-> ##[0:2]
    (sfr_wr && !sfr_sel && wdata == 8'h00)) else $error("enable not cleared");
  chk_write_enabled: assert property (xm_wr |-> ctl_q[FPWG_WREN_BIT])
    else $error("flash write with enable clear");
  chk_read_plain: assert property (code_rd |-> ctl_q == 2'h0 && !stall)
    else $error("code read while enabled");
  chk_one_strobe: assert property ($onehot0({sfr_wr, xm_wr, code_rd}))
    else $error("two strobes at once");
endmodule : fpwg_sva
`default_nettype wire

// [bench/fpwg_tb_top.sv]
/*
  Testbench joining both ends of the write guard over the core-side bus.
  Assumes the package constants and short operation counts of 5 and 20.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module fpwg_tb_top;
  import fpwg_pkg::*;
  logic CLK, RESET, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
  logic awready, wready, arready, ram_wr, dbg_rd, dbg_wr, dbg_ack, dbg_denied;
  logic prog_en, erase_en, unlocked, ers;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, s;
  logic [1:0] bresp, rresp;
  logic [12:0] dbg_addr, a, b;
  logic [7:0] dbg_wdata, dbg_rdata;
  logic [7:0] d [4];
  logic [67:0] n;
  logic [67:0] rq [$];
  logic [1:0] bq [$];
  int num_errors = 0;
  int tests_run = 0;
  fpwg_if bus_if ();
  fpwg_ctl fpwg_ctl_i (.CLK(CLK), .RESET(RESET), .BUS(bus_if),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  fpwg_dev #(.ERASE_CYCLES(20), .WRITE_CYCLES(5)) fpwg_dev_i (.CLK(CLK),
    .RESET(RESET), .BUS(bus_if), .RAM_WR(ram_wr), .RAM_ADDR(), .RAM_WDATA(),
    .DBG_RD(dbg_rd), .DBG_WR(dbg_wr), .DBG_ADDR(dbg_addr),
    .DBG_WDATA(dbg_wdata), .DBG_RDATA(dbg_rdata), .DBG_ACK(dbg_ack),
    .DBG_DENIED(dbg_denied), .PROG_ENABLE(prog_en),
    .ERASE_ENABLE(erase_en), .UNLOCKED(unlocked));
  fpwg_sva fpwg_sva_i (.CLK(CLK), .RESET(RESET), .sfr_wr(bus_if.sfr_wr),
    .sfr_sel(bus_if.sfr_sel), .xm_wr(bus_if.xm_wr), .code_rd(bus_if.code_rd),
    .mem_addr(bus_if.mem_addr), .wdata(bus_if.wdata),
    .code_rdata(bus_if.code_rdata), .stall(bus_if.stall));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (30000) @(posedge CLK);
    num_errors++;
    report_and_stop();
  end

  // scoreboard: oldest note against each answer
  always @(negedge CLK) begin
    if (bvalid && bready) `CHK(bresp, bq.pop_front())
    if (rvalid && rready) begin
      n = rq.pop_front();
      `CHK({rresp, rdata} & n[67:34], n[33:0])
    end
    if (bus_if.stall) begin
      `CHK(prog_en, 1'b1)
      `CHK(erase_en, ers)
      `CHK(unlocked, 1'b0)
    end
    `CHK(ram_wr, 1'b0)
  end

  task automatic axi_wr(input logic [4:0] ad, input logic [31:0] dt,
                        input logic [1:0] er);
    bq.push_back(er);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(negedge CLK); while (!(awready && wready));
    @(posedge CLK);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge CLK); while (!bvalid);
    @(posedge CLK);
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] ad, input logic [33:0] m, e,
                        output logic [31:0] dt);
    rq.push_back({m, e});
    araddr <= ad;
    arvalid <= 1'b1;
    do @(negedge CLK); while (!arready);
    @(posedge CLK);
    arvalid <= 1'b0;
    do @(negedge CLK); while (!rvalid);
    dt = rdata;
    @(posedge CLK);
  endtask : axi_rd

  task automatic flash_op(input logic [1:0] c, input logic [12:0] ad,
                          input logic [7:0] dt, output logic [31:0] st);
    ers = (c == FPWG_CMD_ERASE);
    axi_wr(FPWG_REG_ADDR, {19'h0, ad}, FPWG_RESP_OKAY);
    axi_wr(FPWG_REG_DATA, {24'h0, dt}, FPWG_RESP_OKAY);
    axi_wr(FPWG_REG_CMD, {30'h0, c}, FPWG_RESP_OKAY);
    st = 32'h0;
    while (!(st[FPWG_ST_DONE] || st[FPWG_ST_ERR])) begin
      axi_rd(FPWG_REG_STATUS, 34'h0, 34'h0, st);
    end
    axi_wr(FPWG_REG_STATUS, 32'h6, FPWG_RESP_OKAY);
    `CHK(prog_en, 1'b0)
    `CHK(erase_en, 1'b0)
  endtask : flash_op

  task automatic check_byte(input logic [12:0] ad, input logic [7:0] e);
    logic [31:0] st;
    flash_op(FPWG_CMD_READ, ad, 8'h00, st);
    axi_rd(FPWG_REG_RDATA, 34'h3_0000_00FF, {FPWG_RESP_OKAY, 24'h0, e}, st);
  endtask : check_byte

  task automatic dbg(input logic wr, input logic [12:0] ad, input logic ack,
                     input logic [7:0] e);
    dbg_rd <= !wr;
    dbg_wr <= wr;
    dbg_addr <= ad;
    dbg_wdata <= 8'h00;
    @(posedge CLK);
    dbg_rd <= 1'b0;
    dbg_wr <= 1'b0;
    #1;
    `CHK(dbg_ack, ack)
    `CHK(dbg_denied, !ack)
    if (ack) `CHK(dbg_rdata, e)
    @(posedge CLK);
  endtask : dbg

  initial begin
    RESET = 1'b1;
    {awvalid, wvalid, arvalid, dbg_rd, dbg_wr, ers} = '0;
    {awaddr, araddr, wdata, dbg_addr, dbg_wdata} = '0;
    bready = 1'b1;
    rready = 1'b1;
    void'($urandom(32'hC1C0AB02));
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    `CHK({prog_en, erase_en, unlocked}, 3'h0)
    axi_rd(FPWG_REG_STATUS, 34'h3_FFFF_FFFF, 34'h0, s);
    axi_rd(5'h14, 34'h3_0000_0000, {FPWG_RESP_SLVERR, 32'h0}, s);
    axi_wr(5'h18, 32'h0, FPWG_RESP_SLVERR);
    a = 13'($urandom_range(0, 32'h1BFE));
    b = (a | 13'h01FF) + 13'h0001;
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'($urandom);
    end
    flash_op(FPWG_CMD_PROG, a, d[0], s);
    flash_op(FPWG_CMD_PROG, b, d[1], s);
    check_byte(a, d[0]);
    flash_op(FPWG_CMD_ERASE, a, 8'h00, s);
    check_byte(a, FPWG_ERASED);
    check_byte(a | 13'h01FF, FPWG_ERASED);
    check_byte(b, d[1]);
    flash_op(FPWG_CMD_PROG, a, d[2], s);
    flash_op(FPWG_CMD_PROG, a, d[3], s);
    check_byte(a, d[2] & d[3]);
    dbg(1'b0, a, 1'b1, d[2] & d[3]);
    flash_op(FPWG_CMD_PROG, 13'h1E00 | 13'($urandom_range(0, 511)), 8'h00, s);
    `CHK(s[FPWG_ST_ERR], 1'b1)
    flash_op(FPWG_CMD_PROG, FPWG_LOCK_ADDR, 8'h00, s);
    dbg(1'b0, a, 1'b0, 8'h00);
    dbg(1'b1, a, 1'b0, 8'h00);
    check_byte(a, d[2] & d[3]);
    report_and_stop();
  end
endmodule : fpwg_tb_top
`default_nettype wire
